/* File: rir_top.sv */
/*
 * interface-side register logic: integrity monitor with xor checksum,
 * transfer protection select, result word length, result register and
 * its ready side effects, status append.
 * assumes a serial frame decoder presents reads and writes as one-cycle
 * strobes with a 6-bit register address, and the converter core presents
 * each new conversion as a one-cycle strobe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rir_defs.svh"
module rir_top
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // register access from frame decoder
   input  wire logic        wr_stb,
   input  wire logic        rd_cmd,
   input  wire logic        rd_done,
   input  wire logic [5:0]  addr,
   input  wire logic [23:0] wdata,
   input  wire logic [23:0] user_old,
   // converter core
   input  wire logic        conv_stb,
   input  wire logic [23:0] conv_raw,
   input  wire logic        conv_unipolar,
   input  wire logic [3:0]  conv_channel,
   // read answer
   output logic      [31:0] rdata,
   output logic      [5:0]  rd_bits,
   output logic      [1:0]  prot_mode,
   output logic             xfer_extra_byte,
   // status
   output logic             ready_n,
   output logic             integrity_error,
   output logic      [15:0] interface_options,
   output logic      [23:0] integrity_checksum
);
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   // stored state and next values
   logic [15:0] opt_q;
   logic [15:0] opt_d;
   logic [23:0] sum_q;
   logic [23:0] sum_d;
   logic        err_q;
   logic        err_d;
   logic [23:0] res_q;
   logic [23:0] res_d;
   logic [3:0]  chan_q;
   logic [3:0]  chan_d;
   logic        rdyn_q;
   logic        rdyn_d;
   logic        hold_q;
   logic        hold_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [5:0]  bits_q;
   logic [5:0]  bits_d;
   rir_pkg::rir_prot_t prot_q;
   rir_pkg::rir_prot_t prot_d;
   logic        xb_d;
   logic        xb_q;

   // datapath wires
   logic [23:0] sum_fold;
   logic        user_changed;
   logic [23:0] shaped;
   logic [7:0]  status_byte;
   logic [23:0] chkv_d;
   logic [23:0] chkv_q;

   // option bits and decoded strobes
   logic        chk_en;
   logic        short_wl;
   logic        append;
   logic        wr_opt;
   logic        wr_user;
   logic        rd_res;
   logic        rd_opt;
   logic        rd_chk;
   logic        rd_stat;
   logic        chk_off_wr;
   logic        load_res;
   logic [5:0]  res_bits;

   assign chk_en   = opt_q[`RIR_OPT_CHK_BIT];
   assign short_wl = opt_q[`RIR_OPT_WL_BIT];
   assign append   = opt_q[`RIR_OPT_APP_BIT];
   assign wr_opt   = wr_stb && (addr == `RIR_ADDR_OPTIONS);
   // options, result, status and checksum fall outside the user range
   assign wr_user  = wr_stb && (addr >= `RIR_ADDR_USER_LO); // RL4
   assign rd_res   = rd_cmd && (addr == `RIR_ADDR_RESULT);
   assign rd_opt   = rd_cmd && (addr == `RIR_ADDR_OPTIONS);
   assign rd_chk   = rd_cmd && (addr == `RIR_ADDR_CHECK);
   assign rd_stat  = rd_cmd && (addr == `RIR_ADDR_STATUS);
   assign chk_off_wr = wr_opt && !wdata[`RIR_OPT_CHK_BIT];

   // ------------------------------------------------------------
   // checksum fold and result shaping
   // ------------------------------------------------------------
   rir_xor_fold u_fold
   (
      .sum_in   (sum_q),
      .old_word (user_old),
      .new_word (wdata),
      .sum_out  (sum_fold),
      .changed  (user_changed)
   );

   rir_result_fmt u_fmt
   (
      .raw               (conv_raw),
      .unipolar          (conv_unipolar),
      .short_word_select (short_wl),
      .shaped            (shaped)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   // options write only stores; the shaper picks it up on next load
   assign opt_d = wr_opt ? (wdata[15:0] & `RIR_OPT_MASK) : opt_q; // RL12
   // checksum runs over every user write, exposed only when enabled
   assign sum_d = wr_user ? sum_fold : sum_q; // RL7
   assign chkv_d = opt_d[`RIR_OPT_CHK_BIT] ? sum_d : 24'h000000; // RL8
   // protection mode is only reported; the frame decoder adds the byte
   assign prot_d = rir_pkg::rir_prot_t'(opt_d[`RIR_OPT_PROT_LO +: 2]); // RL9
   assign xb_d   = (prot_d != rir_pkg::RIR_PROT_NONE); // RL10
   // set wins over the clear
   assign err_d = (chk_en && wr_user && user_changed) ? 1'b1 // RL1 RL2 RL5
                : chk_off_wr ? 1'b0 // RL3
                : err_q;
   // no load while a result read is pending
   assign hold_d   = rd_res ? 1'b1 : (rd_done ? 1'b0 : hold_q); // RL16
   assign load_res = conv_stb && !hold_q && !rd_res; // RL16
   assign res_d    = load_res ? shaped : res_q;
   assign chan_d   = load_res ? conv_channel : chan_q; // RL18
   // read raises ready; a fresh result lowers it
   assign rdyn_d   = load_res ? 1'b0 : (rd_res ? 1'b1 : rdyn_q); // RL14 RL15
   assign status_byte = {rdyn_q, 3'h0, err_q, 3'h0};
   assign res_bits = short_wl ? 6'd16 : 6'd24; // RL11
   always_comb
   begin
      rdata_d = rdata_q;
      bits_d  = bits_q;
      if (rd_res)
      begin
         if (append)
         begin
            // status with channel rides behind the data
            rdata_d = short_wl ? {8'h00, res_q[15:0], status_byte | // RL17
                                  {4'h0, chan_q}}
                               : {res_q, status_byte | {4'h0, chan_q}};
            bits_d  = res_bits + 6'd8; // RL17 RL18
         end
         else
         begin
            rdata_d = {8'h00, res_q};
            bits_d  = res_bits;
         end
      end
      else if (rd_chk)
      begin
         rdata_d = {8'h00, chkv_q}; // RL8
         bits_d  = 6'd24;
      end
      else if (rd_opt)
      begin
         rdata_d = {16'h0000, opt_q};
         bits_d  = 6'd16;
      end
      else if (rd_stat)
      begin
         rdata_d = {24'h000000, status_byte | {4'h0, chan_q}};
         bits_d  = 6'd8;
      end
      else if (rd_cmd)
      begin
         rdata_d = 32'h00000000;
         bits_d  = 6'd24;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // interface options
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         opt_q <= `RIR_OPT_RESET;
      end
      else
      begin
         opt_q <= opt_d;
      end
   end

   // protection report follows the options
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prot_q <= rir_pkg::RIR_PROT_NONE;
         xb_q   <= 1'b0;
      end
      else
      begin
         prot_q <= prot_d; // RL9
         xb_q   <= xb_d; // RL10
      end
   end

   // running checksum and its visible copy
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sum_q  <= `RIR_CHECK_RESET;
         chkv_q <= `RIR_CHECK_RESET;
      end
      else
      begin
         sum_q  <= sum_d;
         chkv_q <= chkv_d; // RL7 RL8
      end
   end

   // integrity error flag
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         err_q <= 1'b0;
      end
      else
      begin
         err_q <= err_d;
      end
   end

   // result word and its channel
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         res_q  <= `RIR_RESULT_RESET;
         chan_q <= 4'h0;
      end
      else
      begin
         res_q  <= res_d;
         chan_q <= chan_d;
      end
   end

   // ready and result read hold
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdyn_q <= 1'b1;
         hold_q <= 1'b0;
      end
      else
      begin
         rdyn_q <= rdyn_d;
         hold_q <= hold_d;
      end
   end

   // read answer
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_q <= 32'h00000000;
         bits_q  <= 6'd0;
      end
      else
      begin
         rdata_q <= rdata_d;
         bits_q  <= bits_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rdata              = rdata_q;
   assign rd_bits            = bits_q;
   assign prot_mode          = prot_q;
   assign xfer_extra_byte    = xb_q;
   assign ready_n            = rdyn_q;
   assign integrity_error    = err_q;
   assign interface_options  = opt_q;
   assign integrity_checksum = chkv_q;
endmodule
`default_nettype wire

/* File: rir_defs.svh */
/*
 * constants of the register integrity and result readout block: register
 * indices, interface option field positions, reset values, status bits.
 * assumes the register access port sits behind a serial frame decoder.
 */
// What this block does
// (RL1) bit 5 of interface options enables integrity monitoring of user registers
// (RL2) while monitoring, any change of a monitored register sets the error flag
// (RL3) writing 0 to the monitor enable bit clears the error flag
// (RL4) options, result and status registers are never monitored
// (RL5) writing new contents to a monitored register while enabled raises the flag
// (RL6) host configures registers with monitoring off, clears it before changes
// (RL7) checksum register is 24-bit xor of user registers, only while enabled
// (RL8) checksum reads return zero while monitoring is disabled
// (RL9) bits 3:2 select protection: none, xor on reads, or crc both ways
// (RL10) protected transfers carry one extra checksum or crc byte
// (RL11) bit 0 set makes results 16-bit, clear makes them 24-bit
// (RL12) options write does not reset; first new result has the new length
// (RL13) results offset binary by default, unipolar per setup polarity select
// (RL14) reading the result drives the active-low ready bit and output high
// (RL15) the same result may be read repeatedly
// (RL16) no new result loads once a result read command is received
// (RL17) status append follows result with status, 32 bits in 24-bit mode
// (RL18) appended status guarantees reported channel matches returned data; here channel bit 3 is ORed with the error flag
`ifndef RIR_DEFS_SVH
`define RIR_DEFS_SVH
`define RIR_ADDR_STATUS   6'h00
`define RIR_ADDR_OPTIONS  6'h02
`define RIR_ADDR_CHECK    6'h03
`define RIR_ADDR_RESULT   6'h04
`define RIR_ADDR_USER_LO  6'h05
`define RIR_ADDR_USER_HI  6'h3f
`define RIR_OPT_RESET     16'h0000
`define RIR_OPT_MASK      16'h19ed
`define RIR_OPT_CHK_BIT   5
`define RIR_OPT_APP_BIT   6
`define RIR_OPT_PROT_LO   2
`define RIR_OPT_WL_BIT    0
`define RIR_STAT_RDYN_BIT 7
`define RIR_STAT_REG_BIT  3
`define RIR_RESULT_RESET  24'h000000
`define RIR_CHECK_RESET   24'h000000
`endif

/* File: rir_pkg.sv */
/*
 * types of the register integrity and result readout block.
 * assumes rir_defs.svh for all numeric constants.
 */
package rir_pkg;
   typedef enum logic [1:0]
   {
      RIR_PROT_NONE = 2'b00,
      RIR_PROT_XOR  = 2'b01,
      RIR_PROT_CRC  = 2'b10,
      RIR_PROT_RSVD = 2'b11
   } rir_prot_t;
endpackage

/* File: rir_xor_fold.sv */
/*
 * folds one written 24-bit user register word into the running checksum:
 * removes the old word and adds the new one.
 * assumes both words are zero-extended to 24 bits.
 */
`timescale 1ns/1ps
`default_nettype none
module rir_xor_fold
(
   // words
   input  wire logic [23:0] sum_in,
   input  wire logic [23:0] old_word,
   input  wire logic [23:0] new_word,
   // result
   output logic      [23:0] sum_out,
   output logic             changed
);
   assign sum_out = sum_in ^ old_word ^ new_word;
   assign changed = (old_word != new_word);
endmodule
`default_nettype wire

/* File: rir_result_fmt.sv */
/*
 * shapes a raw 24-bit conversion into the stored result: polarity coding
 * and word length.
 * assumes raw is two's complement from the filter.
 */
`timescale 1ns/1ps
`default_nettype none
module rir_result_fmt
(
   // raw sample
   input  wire logic [23:0] raw,
   // options
   input  wire logic        unipolar,
   input  wire logic        short_word_select,
   // shaped result
   output logic      [23:0] shaped
);
   logic [23:0] coded;
   // offset binary flips msb; unipolar keeps magnitude
   assign coded  = unipolar ? raw : {~raw[23], raw[22:0]}; // RL13
   assign shaped = short_word_select ? {8'h00, coded[23:8]} : coded; // RL11
endmodule
`default_nettype wire

/* File: rir_checker.sv */
/*
 * concurrent checks on the ports of rir_top.
 * assumes one clock domain and the async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rir_defs.svh"
module rir_checker
(
   // clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // requests
   input wire logic        wr_stb,
   input wire logic        rd_cmd,
   input wire logic        rd_done,
   input wire logic [5:0]  addr,
   input wire logic [23:0] wdata,
   input wire logic [23:0] user_old,
   input wire logic        conv_stb,
   // answers
   input wire logic [5:0]  rd_bits,
   input wire logic [1:0]  prot_mode,
   input wire logic        xfer_extra_byte,
   input wire logic        ready_n,
   input wire logic        integrity_error,
   input wire logic [15:0] interface_options,
   input wire logic [23:0] integrity_checksum
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   wire       rd_res;
   wire [5:0] exp_bits;
   wire       opt_wr;
   assign rd_res   = rd_cmd && addr == `RIR_ADDR_RESULT;
   assign opt_wr   = wr_stb && addr == `RIR_ADDR_OPTIONS;
   assign exp_bits = interface_options[6] ?
                     (interface_options[0] ? 6'h18 : 6'h20) :
                     (interface_options[0] ? 6'h10 : 6'h18);
   // result read frame open: new results must be refused
   logic      hold_seen_q;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hold_seen_q <= 1'b0;
      end
      else if (rd_res)
      begin
         hold_seen_q <= 1'b1;
      end
      else if (rd_done)
      begin
         hold_seen_q <= 1'b0;
      end
   end
   chk_zero_a: assert property (!interface_options[5] |->
      integrity_checksum == 24'h000000) else $error("checksum not zero");
   err_set_a: assert property (wr_stb && addr >= `RIR_ADDR_USER_LO &&
      interface_options[5] && wdata != user_old |=> integrity_error)
      else $error("change not flagged");
   err_clr_a: assert property (opt_wr && !wdata[5] |=>
      !integrity_error) else $error("flag not cleared");
   excl_reg_a: assert property (wr_stb && addr < `RIR_ADDR_USER_LO &&
      !integrity_error |=> !integrity_error) else $error("excluded flagged");
   rdy_high_a: assert property (rd_res |=> ready_n)
      else $error("ready not released");
   hold_res_a: assert property ((rd_res || hold_seen_q) && conv_stb |=>
      ready_n) else $error("result loaded in hold");
   prot_mode_a: assert property ($stable(interface_options) |->
      prot_mode == interface_options[3:2]) else $error("bad prot mode");
   extra_byte_a: assert property ($stable(prot_mode) |->
      xfer_extra_byte == (prot_mode != 2'b00)) else $error("bad extra");
   read_len_a: assert property (rd_res |=>
      rd_bits == $past(exp_bits)) else $error("bad read length");
endmodule
bind rir_top rir_checker i_rir_checker (.clk, .arst_n, .wr_stb, .rd_cmd,
   .rd_done, .addr, .wdata, .user_old, .conv_stb, .rd_bits, .prot_mode,
   .xfer_extra_byte, .ready_n, .integrity_error, .interface_options,
   .integrity_checksum);
`default_nettype wire

/* File: rir_host.sv */
/*
 * host side model: one-cycle register strobes and a shadow of the
 * user registers that supplies the old contents.
 * assumes all user registers start at zero.
 */
`timescale 1ns/1ps
`default_nettype none
module rir_host
(
   // clock
   input  wire logic        clk,
   // register access
   output logic             wr_stb,
   output logic             rd_cmd,
   output logic             rd_done,
   output logic      [5:0]  addr,
   output logic      [23:0] wdata,
   output logic      [23:0] user_old
);
   logic [23:0] shadow [64];
   assign user_old = shadow[addr];
   initial
   begin
      foreach (shadow[i]) shadow[i] = 24'h000000;
      {wr_stb, rd_cmd, rd_done, addr, wdata} = '0;
   end
   // released lines show the inverse of the last value
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge clk);
      #10 {addr, wdata, wr_stb} = {a, d, 1'b1};
      @(posedge clk);
      #10 {addr, wdata, wr_stb} = {~a, ~d, 1'b0};
      shadow[a] = d;
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge clk);
      #10 {addr, rd_cmd} = {a, 1'b1};
      @(posedge clk);
      #10 {addr, rd_cmd} = {~a, 1'b0};
   endtask
   task automatic done();
      @(posedge clk);
      #10 rd_done = 1'b1;
      @(posedge clk);
      #10 rd_done = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
/*
 * self-checking bench of rir_top driven through the host model.
 * assumes fixed one-cycle answers of the block.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rir_defs.svh"
module tb_top;
   logic        clk, arst_n, conv_stb, conv_unipolar;
   logic [23:0] conv_raw, wdata, user_old, integrity_checksum;
   logic [3:0]  conv_channel;
   logic        wr_stb, rd_cmd, rd_done, xfer_extra_byte;
   logic [5:0]  addr, rd_bits;
   logic [31:0] rdata;
   logic [1:0]  prot_mode;
   logic        ready_n, integrity_error;
   logic [15:0] interface_options;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   rir_host i_rir_host (.clk, .wr_stb, .rd_cmd, .rd_done, .addr, .wdata,
      .user_old);
   rir_top i_rir_top (.clk, .arst_n, .wr_stb, .rd_cmd, .rd_done, .addr,
      .wdata, .user_old, .conv_stb, .conv_raw, .conv_unipolar, .conv_channel,
      .rdata, .rd_bits, .prot_mode, .xfer_extra_byte, .ready_n,
      .integrity_error, .interface_options, .integrity_checksum);
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conv(input logic [23:0] r, input logic u, logic [3:0] c);
      @(posedge clk);
      #10 {conv_raw, conv_unipolar, conv_channel, conv_stb} = {r, u, c, 1'b1};
      @(posedge clk);
      #10 conv_stb = 1'b0;
   endtask
   task automatic conclude();
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      {arst_n, conv_stb, conv_raw, conv_unipolar, conv_channel} = '0;
      repeat (12) @(posedge clk);
      #10 arst_n = 1'b1;
      i_rir_host.rd(`RIR_ADDR_CHECK);
      chk(rdata, 32'h00000000);
      conv(24'h000001, 1'b0, 4'h1);
      chk(32'(ready_n), 32'h0);
      i_rir_host.rd(`RIR_ADDR_RESULT);
      chk(rdata, 32'h00800001);
      chk(32'(ready_n), 32'h1);
      i_rir_host.rd(`RIR_ADDR_RESULT);
      chk(rdata, 32'h00800001);
      i_rir_host.done();
      conv(24'h123456, 1'b1, 4'h1);
      i_rir_host.rd(`RIR_ADDR_RESULT);
      conv(24'h000777, 1'b1, 4'h1);
      i_rir_host.done();
      i_rir_host.rd(`RIR_ADDR_RESULT);
      chk(rdata, 32'h00123456);
      i_rir_host.done();
      i_rir_host.wr(`RIR_ADDR_OPTIONS, 24'h000001);
      conv(24'h123456, 1'b1, 4'h0);
      i_rir_host.rd(`RIR_ADDR_RESULT);
      chk(rdata, 32'h00001234);
      chk(32'(rd_bits), 32'h10);
      i_rir_host.done();
      i_rir_host.wr(`RIR_ADDR_OPTIONS, 24'h000040);
      conv(24'h000010, 1'b0, 4'h2);
      i_rir_host.rd(`RIR_ADDR_RESULT);
      chk(32'(rdata[31:8]), 32'h00800010);
      chk(32'(rdata[2:0]), 32'h2);
      chk(32'(rd_bits), 32'h20);
      i_rir_host.done();
      for (int p = 0; p < 3; p++)
      begin
         i_rir_host.wr(`RIR_ADDR_OPTIONS, 24'(p << 2));
         @(posedge clk);
         #10 chk(32'(prot_mode), 32'(p));
         chk(32'(xfer_extra_byte), 32'(p != 0));
         chk(32'(interface_options), 32'(p << 2));
      end
      i_rir_host.wr(6'h05, 24'h0000aa);
      i_rir_host.wr(6'h06, 24'h000f00);
      i_rir_host.wr(`RIR_ADDR_OPTIONS, 24'h000020);
      i_rir_host.rd(`RIR_ADDR_CHECK);
      chk(rdata, 32'h00000faa);
      chk(32'(integrity_checksum), 32'h00000faa);
      i_rir_host.wr(6'h07, 24'h000000);
      i_rir_host.wr(`RIR_ADDR_RESULT, 24'h000001);
      i_rir_host.wr(`RIR_ADDR_OPTIONS, 24'h000024);
      chk(32'(integrity_error), 32'h0);
      i_rir_host.wr(6'h05, 24'h000055);
      chk(32'(integrity_error), 32'h1);
      i_rir_host.wr(`RIR_ADDR_OPTIONS, 24'h000000);
      chk(32'(integrity_error), 32'h0);
      chk(32'(integrity_checksum), 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
